// ### core/rxdc_pkg.sv
// Constants, types and command codes for the receiver direct command block.
// Assumes one 100 MHz clock and a host that decodes the serial command stream.
//
// Behaviour
// - Mask command drives the receive gate low and disables receive framing.
// - Unmask command drives the receive gate high and enables framing.
// - Unmask while the mask timer runs enables reception and resets the timer.
// - Mask and unmask need receiver enable; chainable, no completion interrupt.
// - Measure amplitude enables transmitter and detector; converts absolute; needs enable, stable oscillator.
// - One code step per 13.02 mVpp; 3 Vpp gives 1110 0110b.
// - Measure amplitude finishes within 25 us.
// - Measure amplitude raises completion interrupt after finishing; not chainable.
// - Squelch finishes within 500 us, not chainable, no interrupt.
// - Squelch accepted only while transmitter and receiver both operate.
// - Accepted squelch runs only if the receive gate is low.
// - Gain reset reinitialises AGC, squelch, RSSI; aborts squelch; needs enable, oscillator.
// - Gain reset loads the manual gain reduction into the active gain.
// - Bit 1 of register 0Ch clips first and second stages; preset 1 in active peer mode.
// - Bit 0 of register 0Ch forces gain cut in stages two and three; same preset.
package rxdc_pkg;
    localparam logic [5:0] RXDC_REG_CFG3_ADDR   = 6'h0C;
    localparam int         RXDC_STAGE_CLIP_BIT  = 1;
    localparam int         RXDC_PEER_GAIN_BIT   = 0;
    localparam logic [7:0] RXDC_CFG3_RESET      = 8'h00;
    localparam logic [7:0] RXDC_CFG3_ACTIVE_PRE = 8'h03;
    localparam logic [3:0] RXDC_GAIN_RESET      = 4'h0;
    localparam logic [7:0] RXDC_ADC_RESET       = 8'h00;
    localparam logic [7:0] RXDC_ADC_FULLSCALE   = 8'hE6;
    localparam int         RXDC_CLK_MHZ         = 100;
    localparam int         RXDC_AMP_TIME_US     = 25;
    localparam int         RXDC_SQL_TIME_US     = 500;
    localparam int         RXDC_AMP_CYCLES      = RXDC_AMP_TIME_US * RXDC_CLK_MHZ;
    localparam int         RXDC_SQL_CYCLES      = RXDC_SQL_TIME_US * RXDC_CLK_MHZ;
    localparam int         RXDC_CNT_W           = 16;
    localparam int         RXDC_MV_PER_CODE_X100 = 1302;
    typedef enum logic [2:0] {
        RXDC_CMD_NONE, RXDC_CMD_MASK, RXDC_CMD_UNMASK,
        RXDC_CMD_AMP, RXDC_CMD_SQUELCH, RXDC_CMD_GAIN_RST
    } rxdc_cmd_t;
    typedef enum {RXDC_IDLE, RXDC_AMP, RXDC_SQL} rxdc_state_t;
endpackage

// ### core/rxdc_cfg3.sv
// Receiver configuration register 3 with its active peer mode preset.
// Assumes a decoded register write strobe and a preset pulse from mode logic.
`timescale 1ns/10ps
module rxdc_cfg3
    import rxdc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       preset_stb,
    input  wire logic       preset_active,
    output logic      [7:0] cfg3_q
);
    logic [7:0] cfg3_d;

    always_comb begin
        cfg3_d = cfg3_q;
        if (wr_en) begin
            cfg3_d = wr_data;
        end else if (preset_stb) begin
            cfg3_d[RXDC_STAGE_CLIP_BIT] = preset_active;
            cfg3_d[RXDC_PEER_GAIN_BIT]  = preset_active;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg3_q <= RXDC_CFG3_RESET;
        end else begin
            cfg3_q <= cfg3_d;
        end
    end

    a_preset_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (preset_stb && !wr_en) |=> (cfg3_q[1:0] == {2{$past(preset_active)}}))
        else $error("preset did not load clip and gain cut bits");
endmodule // rxdc_cfg3

// ### core/rxdc_top.sv
// Receiver direct command interpreter: mask, amplitude, squelch, gain reset.
// Assumes commands arrive as one-cycle strobes from the serial interface decoder.
`timescale 1ns/10ps
module rxdc_top
    import rxdc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       cmd_stb,
    input  wire rxdc_cmd_t  cmd_code,
    input  wire logic       chip_en,
    input  wire logic       osc_stable,
    input  wire logic       rx_en,
    input  wire logic       tx_en,
    input  wire logic       mask_timer_run,
    input  wire logic       reg_wr,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       mode_preset_stb,
    input  wire logic       mode_active_peer,
    input  wire logic [3:0] manual_gain,
    input  wire logic [7:0] amp_adc_code,
    input  wire logic       amp_adc_done,
    output logic            rx_gate_q,
    output logic            framing_en_q,
    output logic            mask_timer_clr_q,
    output logic            tx_force_q,
    output logic            amp_det_en_q,
    output logic            adc_absolute_q,
    output logic [7:0]      adc_result_q,
    output logic            cmd_done_irq_q,
    output logic            squelch_run_q,
    output logic            rx_gain_init_q,
    output logic [3:0]      active_gain_q,
    output logic            busy_q,
    output logic [7:0]      cfg3_q
);
    function automatic logic osc_ok(input logic en, input logic stab);
        return en && stab;
    endfunction

    rxdc_state_t           state_q, state_d;
    logic [RXDC_CNT_W-1:0] cnt_q, cnt_d;
    logic                  rx_gate_d, framing_en_d, mask_timer_clr_d, tx_force_d;
    logic                  amp_det_en_d, adc_absolute_d, cmd_done_irq_d;
    logic                  squelch_run_d, rx_gain_init_d, busy_d;
    logic [7:0]            adc_result_d;
    logic [3:0]            active_gain_d;
    logic                  cfg3_wr;
    logic                  acc_mask, acc_unmask, acc_amp, acc_sql, acc_grst;
    logic [RXDC_CNT_W-1:0] amp_wait_q, amp_wait_d;

    assign cfg3_wr = reg_wr && (reg_addr == RXDC_REG_CFG3_ADDR);

    // ----------------------------------------
    // Acceptance
    // ----------------------------------------
    always_comb begin
        acc_mask   = cmd_stb && cmd_code == RXDC_CMD_MASK && rx_en;
        acc_unmask = cmd_stb && cmd_code == RXDC_CMD_UNMASK && rx_en;
        acc_amp    = cmd_stb && cmd_code == RXDC_CMD_AMP && osc_ok(chip_en, osc_stable)
                     && state_q == RXDC_IDLE;
        acc_sql    = cmd_stb && cmd_code == RXDC_CMD_SQUELCH && tx_en && rx_en
                     && state_q == RXDC_IDLE;
        acc_grst   = cmd_stb && cmd_code == RXDC_CMD_GAIN_RST
                     && osc_ok(chip_en, osc_stable);
    end

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always_comb begin
        state_d          = state_q;
        cnt_d            = cnt_q;
        rx_gate_d        = rx_gate_q;
        framing_en_d     = framing_en_q;
        mask_timer_clr_d = 1'b0;
        tx_force_d       = tx_force_q;
        amp_det_en_d     = amp_det_en_q;
        adc_absolute_d   = adc_absolute_q;
        adc_result_d     = adc_result_q;
        cmd_done_irq_d   = 1'b0;
        squelch_run_d    = squelch_run_q;
        rx_gain_init_d   = 1'b0;
        active_gain_d    = active_gain_q;
        if (acc_mask) begin
            rx_gate_d    = 1'b0;
            framing_en_d = 1'b0;
        end
        if (acc_unmask) begin
            rx_gate_d    = 1'b1;
            framing_en_d = 1'b1;
            if (mask_timer_run) begin
                mask_timer_clr_d = 1'b1;
            end
        end
        if (acc_grst) begin
            rx_gain_init_d = 1'b1;
            active_gain_d  = manual_gain;
        end
        case (state_q)
            RXDC_IDLE: begin
                if (acc_amp) begin
                    state_d        = RXDC_AMP;
                    cnt_d          = '0;
                    tx_force_d     = 1'b1;
                    amp_det_en_d   = 1'b1;
                    adc_absolute_d = 1'b1;
                end else if (acc_sql && !rx_gate_q) begin
                    state_d       = RXDC_SQL;
                    cnt_d         = '0;
                    squelch_run_d = 1'b1;
                end
            end
            RXDC_AMP: begin
                cnt_d = cnt_q + 1'b1;
                if (amp_adc_done || cnt_q == RXDC_CNT_W'(RXDC_AMP_CYCLES - 2)) begin
                    adc_result_d   = amp_adc_done ? amp_adc_code : adc_result_q;
                    tx_force_d     = 1'b0;
                    amp_det_en_d   = 1'b0;
                    adc_absolute_d = 1'b0;
                    cmd_done_irq_d = 1'b1;
                    state_d        = RXDC_IDLE;
                end
            end
            RXDC_SQL: begin
                cnt_d = cnt_q + 1'b1;
                if (acc_grst || cnt_q == RXDC_CNT_W'(RXDC_SQL_CYCLES - 2)) begin
                    squelch_run_d = 1'b0;
                    state_d       = RXDC_IDLE;
                end
            end
            default: begin
                state_d = RXDC_IDLE;
            end
        endcase
        busy_d = (state_d != RXDC_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q          <= RXDC_IDLE;
            cnt_q            <= '0;
            rx_gate_q        <= 1'b1;
            framing_en_q     <= 1'b1;
            mask_timer_clr_q <= 1'b0;
            tx_force_q       <= 1'b0;
            amp_det_en_q     <= 1'b0;
            adc_absolute_q   <= 1'b0;
            adc_result_q     <= RXDC_ADC_RESET;
            cmd_done_irq_q   <= 1'b0;
            squelch_run_q    <= 1'b0;
            rx_gain_init_q   <= 1'b0;
            active_gain_q    <= RXDC_GAIN_RESET;
            busy_q           <= 1'b0;
        end else begin
            state_q          <= state_d;
            cnt_q            <= cnt_d;
            rx_gate_q        <= rx_gate_d;
            framing_en_q     <= framing_en_d;
            mask_timer_clr_q <= mask_timer_clr_d;
            tx_force_q       <= tx_force_d;
            amp_det_en_q     <= amp_det_en_d;
            adc_absolute_q   <= adc_absolute_d;
            adc_result_q     <= adc_result_d;
            cmd_done_irq_q   <= cmd_done_irq_d;
            squelch_run_q    <= squelch_run_d;
            rx_gain_init_q   <= rx_gain_init_d;
            active_gain_q    <= active_gain_d;
            busy_q           <= busy_d;
        end
    end

    rxdc_cfg3 u_cfg3 (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .wr_en         (cfg3_wr),
        .wr_data       (reg_wdata),
        .preset_stb    (mode_preset_stb),
        .preset_active (mode_active_peer),
        .cfg3_q        (cfg3_q)
    );

    // ----------------------------------------
    // Amplitude time guard
    // ----------------------------------------
    // Cycles since amplitude start, cleared by the completion pulse
    always_comb begin
        amp_wait_d = amp_wait_q;
        if (acc_amp) begin
            amp_wait_d = RXDC_CNT_W'(1);
        end else if (cmd_done_irq_q) begin
            amp_wait_d = '0;
        end else if (amp_wait_q != '0) begin
            amp_wait_d = amp_wait_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            amp_wait_q <= '0;
        end else begin
            amp_wait_q <= amp_wait_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_mask_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_mask && !acc_unmask) |=> (!rx_gate_q && !framing_en_q))
        else $error("mask did not close the receive gate");
    a_unmask_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_unmask |=> (rx_gate_q && framing_en_q))
        else $error("unmask did not open the receive gate");
    a_timer_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_unmask && mask_timer_run) |=> mask_timer_clr_q)
        else $error("mask timer not reset on unmask");
    a_mask_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cmd_stb && cmd_code == RXDC_CMD_MASK && !rx_en && rx_gate_q) |=> rx_gate_q)
        else $error("mask taken without receiver enable");
    a_amp_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_amp |=> (tx_force_q && amp_det_en_q && adc_absolute_q))
        else $error("amplitude path not enabled");
    a_amp_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (amp_wait_q != '0) |-> (amp_wait_q <= RXDC_CNT_W'(RXDC_AMP_CYCLES)))
        else $error("amplitude measurement exceeded its time");
    a_irq_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cmd_done_irq_q |-> ($past(state_q) == RXDC_AMP && state_q == RXDC_IDLE))
        else $error("completion interrupt without amplitude end");
    a_sql_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (acc_sql && rx_gate_q) |=> !squelch_run_q)
        else $error("squelch ran with open receive gate");
    a_sql_needs: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(squelch_run_q) |-> $past(tx_en && rx_en))
        else $error("squelch ran without transmitter and receiver");
    a_gain_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_grst |=> (active_gain_q == $past(manual_gain) && rx_gain_init_q && !squelch_run_q))
        else $error("gain reset did not load manual gain");
endmodule // rxdc_top

// ### sim/rxdc_fe_model.sv
// Front-end model: amplitude detector and converter that answer the block.
// Assumes the block holds detector enable and absolute mode during a conversion.
`timescale 1ns/10ps
module rxdc_fe_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        amp_det_en,
    input  wire logic        adc_absolute,
    input  wire logic [11:0] lat,
    input  wire logic [7:0]  code,
    output logic      [7:0]  amp_adc_code,
    output logic             amp_adc_done
);
    // ----------------------------------------
    // Conversion timing
    // ----------------------------------------
    logic [11:0] cnt_q;
    logic        conv;
    logic        hit;
    assign conv = amp_det_en && adc_absolute;
    // Zero latency: converter never answers
    assign hit = rst_n && conv && (lat != 12'h000) && (cnt_q == lat);
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !conv) begin
            cnt_q <= 12'h000;
        end else begin
            cnt_q <= cnt_q + 12'h001;
        end
        amp_adc_done <= hit;
        // Outside the answer cycle the code changes every cycle during a conversion and holds FFh between conversions
        amp_adc_code <= hit ? code : ~cnt_q[7:0];
    end
endmodule // rxdc_fe_model

// ### sim/rxdc_top_tb.sv
// Self-checking testbench of the receiver direct command block.
// Assumes the front-end model answers amplitude conversions unless lat is zero.
`timescale 1ns/10ps
module rxdc_top_tb import rxdc_pkg::*;;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_stb = 1'b0;
    rxdc_cmd_t   cmd_code = RXDC_CMD_NONE;
    logic        chip_en = 1'b1;
    logic        osc_stable = 1'b1;
    logic        rx_en = 1'b0;
    logic        tx_en = 1'b0;
    logic        mask_timer_run = 1'b0;
    logic        reg_wr = 1'b0;
    logic [5:0]  reg_addr = 6'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        mode_preset_stb = 1'b0;
    logic        mode_active_peer = 1'b0;
    logic [3:0]  manual_gain = 4'h0;
    logic [11:0] lat = 12'h064;
    logic [7:0]  code = 8'hE6;
    logic [7:0]  amp_adc_code;
    logic        amp_adc_done;
    logic        rx_gate_q, framing_en_q, mask_timer_clr_q, tx_force_q, amp_det_en_q, adc_absolute_q;
    logic        cmd_done_irq_q, squelch_run_q, rx_gain_init_q, busy_q;
    logic [7:0]  adc_result_q;
    logic [7:0]  cfg3_q;
    logic [3:0]  active_gain_q;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_irq = 0;
    int          n_clr = 0;
    int          n_init = 0;
    int          n;
    always #5 sys_clk = ~sys_clk;
    rxdc_top i_dut (.sys_clk, .rst_n, .cmd_stb, .cmd_code, .chip_en, .osc_stable, .rx_en, .tx_en,
        .mask_timer_run, .reg_wr, .reg_addr, .reg_wdata, .mode_preset_stb, .mode_active_peer, .manual_gain,
        .amp_adc_code, .amp_adc_done, .rx_gate_q, .framing_en_q, .mask_timer_clr_q, .tx_force_q,
        .amp_det_en_q, .adc_absolute_q, .adc_result_q, .cmd_done_irq_q, .squelch_run_q, .rx_gain_init_q,
        .active_gain_q, .busy_q, .cfg3_q);
    rxdc_fe_model i_fe (.sys_clk, .rst_n, .amp_det_en(amp_det_en_q), .adc_absolute(adc_absolute_q),
        .lat, .code, .amp_adc_code, .amp_adc_done);
    // Pulse counters
    always @(posedge sys_clk) begin
        if (cmd_done_irq_q === 1'b1) n_irq++;
        if (mask_timer_clr_q === 1'b1) n_clr++;
        if (rx_gain_init_q === 1'b1) n_init++;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input rxdc_cmd_t c);
        @(negedge sys_clk);
        cmd_stb = 1'b1;
        cmd_code = c;
        @(negedge sys_clk);
        cmd_stb = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic w, input logic [5:0] a, input logic [7:0] d, input logic ps, input logic act);
        @(negedge sys_clk);
        {reg_wr, reg_addr, reg_wdata, mode_preset_stb, mode_active_peer} = {w, a, d, ps, act};
        @(negedge sys_clk);
        {reg_wr, mode_preset_stb} = 2'b00;
        @(negedge sys_clk);
    endtask
    task automatic wait_idle(input int lim, output int cnt);
        cnt = 0;
        while (busy_q !== 1'b0) begin
            @(negedge sys_clk);
            cnt++;
            if (cnt > lim) begin
                n_mismatch++;
                $display("MISMATCH at %0t: busy never dropped", $time);
                print_verdict();
            end
        end
        // Let the pulse counters take the completion pulse
        @(negedge sys_clk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk({rx_gate_q, framing_en_q, busy_q, active_gain_q}, 7'b110_0000);
        chk({adc_result_q, cfg3_q}, 16'h0000);
        cmd(RXDC_CMD_MASK);
        chk(rx_gate_q, 1'b1);
        rx_en = 1'b1;
        cmd(RXDC_CMD_MASK);
        chk({rx_gate_q, framing_en_q}, 2'b00);
        cmd(RXDC_CMD_SQUELCH);
        chk(squelch_run_q, 1'b0);
        mask_timer_run = 1'b1;
        cmd(RXDC_CMD_UNMASK);
        mask_timer_run = 1'b0;
        chk({rx_gate_q, framing_en_q}, 2'b11);
        chk(n_clr, 1);
        tx_en = 1'b1;
        cmd(RXDC_CMD_SQUELCH);
        chk(squelch_run_q, 1'b0);
        cmd(RXDC_CMD_MASK);
        cmd(RXDC_CMD_SQUELCH);
        chk({squelch_run_q, busy_q}, 2'b11);
        manual_gain = 4'hA;
        cmd(RXDC_CMD_GAIN_RST);
        chk({squelch_run_q, busy_q, active_gain_q}, 6'b00_1010);
        chk(n_init, 1);
        cmd(RXDC_CMD_SQUELCH);
        wait_idle(50000, n);
        chk(squelch_run_q, 1'b0);
        chip_en = 1'b0;
        cmd(RXDC_CMD_AMP);
        chk(busy_q, 1'b0);
        manual_gain = 4'h5;
        cmd(RXDC_CMD_GAIN_RST);
        chk({active_gain_q, n_init[3:0]}, 8'hA1);
        chip_en = 1'b1;
        osc_stable = 1'b0;
        cmd(RXDC_CMD_AMP);
        chk(busy_q, 1'b0);
        osc_stable = 1'b1;
        cmd(RXDC_CMD_AMP);
        chk({tx_force_q, amp_det_en_q, adc_absolute_q, busy_q}, 4'hF);
        cmd(RXDC_CMD_AMP);
        wait_idle(2500, n);
        chk({adc_result_q, tx_force_q, amp_det_en_q}, 10'h398);
        chk(n_irq, 1);
        lat = 12'h000;
        code = 8'h3C;
        cmd(RXDC_CMD_AMP);
        wait_idle(2500, n);
        chk({adc_result_q, n_irq[3:0]}, 12'hE62);
        wr(1'b1, 6'h0C, 8'h5A, 1'b0, 1'b0);
        chk(cfg3_q, 8'h5A);
        wr(1'b1, 6'h0D, 8'hFF, 1'b0, 1'b0);
        chk(cfg3_q, 8'h5A);
        wr(1'b0, 6'h0C, 8'h00, 1'b1, 1'b1);
        chk(cfg3_q, 8'h5B);
        wr(1'b0, 6'h0C, 8'h00, 1'b1, 1'b0);
        chk(cfg3_q, 8'h58);
        wr(1'b1, 6'h0C, 8'h81, 1'b1, 1'b1);
        chk(cfg3_q, 8'h81);
        print_verdict();
    end
endmodule // rxdc_top_tb
